// ---- verilog/stsr_pkg.sv ----
// constants and types of the timestamp and status register group
package stsr_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_PERIOD_US = 39;
  localparam int TICK_CYC = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int TICK_CNT_W = 9;
  localparam int TEMP_PERIOD_MS = 10;
  localparam int TEMP_PERIOD_CYC = TEMP_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TEMP_CNT_W = 24;
  localparam int TS_W = 24;
  localparam int TEMP_W = 16;
  localparam int TEMP_ALIGN_BIT = 15;
  localparam logic [TS_W-1:0] TS_RESET = 24'h000000;
  localparam logic [TEMP_W-1:0] TEMP_RESET = 16'h8000;
  localparam logic POR_RESET = 1'b1;
  // register byte addresses
  localparam logic [7:0] ADDR_DATA_FIRST = 8'h12;
  localparam logic [7:0] ADDR_DATA_LAST = 8'h17;
  localparam logic [7:0] ADDR_TS0 = 8'h18;
  localparam logic [7:0] ADDR_TS1 = 8'h19;
  localparam logic [7:0] ADDR_TS2 = 8'h1a;
  localparam logic [7:0] ADDR_STATUS = 8'h1b;
  localparam logic [7:0] ADDR_IRQ = 8'h1d;
  localparam logic [7:0] ADDR_TEMP0 = 8'h20;
  localparam logic [7:0] ADDR_TEMP1 = 8'h21;
  // field positions
  localparam int ST_DRDY = 6;
  localparam int ST_NVM = 4;
  localparam int ST_FOC = 3;
  localparam int ST_SELF = 1;
  localparam int ST_POR = 0;
  localparam int IRQ_FWM = 6;
  localparam int IRQ_FFULL = 5;
  localparam int IRQ_DRDY = 4;
  localparam logic [1:0] THERM_SUSPEND = 2'h0;
  localparam logic [1:0] THERM_NORMAL = 2'h1;
  typedef enum logic [1:0] {
    GYR_SUSPEND = 2'h0,
    GYR_NORMAL = 2'h1,
    GYR_RSVD = 2'h2,
    GYR_FAST = 2'h3
  } stsr_gyr_pmu_t;
  typedef struct packed {
    logic strobe;
    logic first;
    logic [7:0] addr;
  } stsr_rd_t;
  typedef struct packed {
    logic rate_new;
    logic fwm;
    logic ffull;
    logic drdy;
    logic soft_reset;
    logic frame_start;
  } stsr_evt_t;
  typedef struct packed {
    logic nvm_busy;
    logic foc_done;
    logic self_test_ok;
  } stsr_cond_t;
endpackage

// ---- verilog/stsr_regs.sv ----
// timestamp, status, interrupt flag and temperature registers
// Functional notes
// - 24-bit timestamp advances once per 39 us tick
// - timestamp runs in every power mode
// - burst from rate bytes captures timestamp at transfer start and returns it
// - each new fifo frame recaptures the timestamp shadow
// - timestamp starts at zero after reset and wraps after all ones
// - any rate output byte read clears status bit 6
// - status bit 3 shows offset compensation completed
// - status bit 1 high only after self-test passed
// - status bit 0 set by power-on or soft reset, cleared by read
// - interrupt bits 6,5,4 report watermark, full, data ready; 1 active
// - temperature word valid only while gyro is normal
// - temperature signed, zero at 23 degrees, 0x8000 invalid and reset
// - gyro normal refreshes temperature every 10 ms
// - gyro suspended, thermal normal refreshes on timestamp bit 15 edge
// - gyro fast start-up refreshes every 1.28 s even thermal suspended
// - both suspended means no measurement and no update
// - gyro state codes suspend 00, normal 01, fast 11, 10 reserved
`timescale 1ns/1ps
module stsr_regs
  import stsr_pkg::*;
#(
  parameter int TEMP_PERIOD = TEMP_PERIOD_CYC
) (
  input wire logic clk_sys, // 10 mhz system clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire stsr_rd_t rd, // register read request
  output logic [7:0] rd_data, // read data, one cycle after strobe
  input wire stsr_evt_t evt, // one-cycle event pulses
  input wire stsr_cond_t cond, // status levels
  input wire logic [2:0] irq_en, // fwm, ffull, drdy function enables
  input wire stsr_gyr_pmu_t gyr_pmu, // gyro power state
  input wire logic [1:0] thermal_power_state, // thermal power state
  input wire logic [TEMP_W-1:0] temp_sample, // converter result
  output logic temp_meas_en, // temperature measurement active
  output logic temp_valid // temperature word trustworthy
);

  // ********************************
  // reset release
  // ********************************
  logic [1:0] rst_pipe_reg;
  logic rst_s_n;

  // two flops release the reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end
  assign rst_s_n = rst_pipe_reg[1];

  // ********************************
  // decode helpers
  // ********************************
  function automatic logic is_data_addr(input logic [7:0] a);
    is_data_addr = (a >= ADDR_DATA_FIRST) && (a <= ADDR_DATA_LAST);
  endfunction

  logic rd_data_hit;
  logic rd_status_hit;
  logic rd_irq_hit;
  logic capture;
  logic xfer_other;

  // read strobes on the flag registers
  assign rd_data_hit = rd.strobe && is_data_addr(rd.addr);
  assign rd_status_hit = rd.strobe && (rd.addr == ADDR_STATUS);
  assign rd_irq_hit = rd.strobe && (rd.addr == ADDR_IRQ);
  assign capture = (rd.strobe && rd.first && is_data_addr(rd.addr))
                   || evt.frame_start;
  assign xfer_other = rd.strobe && rd.first && !is_data_addr(rd.addr);

  // ********************************
  // time base and timestamp
  // ********************************
  logic [TICK_CNT_W-1:0] tick_cnt_reg;
  logic tick;
  logic [TS_W-1:0] ts_reg;

  assign tick = (tick_cnt_reg == TICK_CNT_W'(TICK_CYC - 1));

  // tick divider, never gated by power mode
  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      tick_cnt_reg <= '0;
    end else if (evt.soft_reset || tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  // counter wraps naturally past all ones
  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      ts_reg <= TS_RESET;
    end else if (evt.soft_reset) begin
      ts_reg <= TS_RESET;
    end else if (tick) begin
      ts_reg <= ts_reg + 1'b1;
    end
  end

  // ********************************
  // timestamp shadow
  // ********************************
  logic [TS_W-1:0] shadow_reg;
  logic shadow_on_reg;
  logic [TS_W-1:0] ts_view;

  // shadow holds the value taken at transfer or frame start
  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      shadow_reg <= TS_RESET;
    end else if (capture) begin
      shadow_reg <= ts_reg;
    end
  end

  // shadow stays in use until a transfer starts elsewhere
  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      shadow_on_reg <= 1'b0;
    end else if (capture) begin
      shadow_on_reg <= 1'b1;
    end else if (xfer_other) begin
      shadow_on_reg <= 1'b0;
    end
  end
  // the first byte of a transfer that starts elsewhere already sees the live count
  assign ts_view = (shadow_on_reg && !xfer_other) ? shadow_reg : ts_reg;

  // ********************************
  // status flags
  // ********************************
  logic drdy_reg;
  logic por_reg;
  logic nvm_rdy_reg;
  logic foc_reg;
  logic self_ok_reg;

  // rate ready: a new sample wins over the clearing read
  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      drdy_reg <= 1'b0;
    end else if (evt.rate_new) begin
      drdy_reg <= 1'b1;
    end else if (rd_data_hit) begin
      drdy_reg <= 1'b0;
    end
  end

  // power-on flag: soft reset wins over the clearing read
  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      por_reg <= POR_RESET;
    end else if (evt.soft_reset) begin
      por_reg <= 1'b1;
    end else if (rd_status_hit) begin
      por_reg <= 1'b0;
    end
  end

  // level flags follow their sources
  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      nvm_rdy_reg <= 1'b0;
      foc_reg <= 1'b0;
      self_ok_reg <= 1'b0;
    end else begin
      nvm_rdy_reg <= !cond.nvm_busy;
      foc_reg <= cond.foc_done;
      self_ok_reg <= cond.self_test_ok;
    end
  end

  // ********************************
  // interrupt flags
  // ********************************
  logic [2:0] irq_reg;
  logic [2:0] irq_set;

  // only enabled functions report
  assign irq_set = {evt.fwm, evt.ffull, evt.drdy} & irq_en;

  // sticky flags cleared by read, set wins
  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      irq_reg <= 3'h0;
    end else if (evt.soft_reset) begin
      irq_reg <= 3'h0;
    end else if (rd_irq_hit) begin
      irq_reg <= irq_set;
    end else begin
      irq_reg <= irq_reg | irq_set;
    end
  end

  // ********************************
  // temperature
  // ********************************
  logic [TEMP_CNT_W-1:0] temp_cnt_reg;
  logic period_evt;
  logic align_prev_reg;
  logic align_evt;
  logic temp_upd;
  logic [TEMP_W-1:0] temp_reg;
  logic valid_reg;
  logic meas_reg;

  assign period_evt = (gyr_pmu == GYR_NORMAL)
                      && (temp_cnt_reg == TEMP_CNT_W'(TEMP_PERIOD - 1));
  assign align_evt = ts_reg[TEMP_ALIGN_BIT] ^ align_prev_reg;

  // 10 ms period counter, idle outside gyro normal
  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      temp_cnt_reg <= '0;
    end else if ((gyr_pmu != GYR_NORMAL) || period_evt) begin
      temp_cnt_reg <= '0;
    end else begin
      temp_cnt_reg <= temp_cnt_reg + 1'b1;
    end
  end

  // edge detector on timestamp bit 15, cleared with the counter so a soft reset
  // does not look like an alignment edge
  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      align_prev_reg <= 1'b0;
    end else if (evt.soft_reset) begin
      align_prev_reg <= 1'b0;
    end else begin
      align_prev_reg <= ts_reg[TEMP_ALIGN_BIT];
    end
  end

  // update schedule per gyro power state
  always_comb begin
    temp_upd = 1'b0;
    unique case (gyr_pmu)
      GYR_NORMAL: temp_upd = period_evt;
      GYR_SUSPEND: temp_upd = (thermal_power_state == THERM_NORMAL)
                              && align_evt;
      GYR_FAST: temp_upd = align_evt;
      GYR_RSVD: temp_upd = 1'b0;
    endcase
  end

  // temperature word, invalid code after reset
  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      temp_reg <= TEMP_RESET;
    end else if (evt.soft_reset) begin
      temp_reg <= TEMP_RESET;
    end else if (temp_upd) begin
      temp_reg <= temp_sample;
    end
  end

  // validity and measurement enable
  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      valid_reg <= 1'b0;
      meas_reg <= 1'b0;
    end else begin
      valid_reg <= (gyr_pmu == GYR_NORMAL);
      meas_reg <= (gyr_pmu == GYR_NORMAL) || (gyr_pmu == GYR_FAST)
                  || ((gyr_pmu == GYR_SUSPEND)
                      && (thermal_power_state == THERM_NORMAL));
    end
  end
  assign temp_valid = valid_reg;
  assign temp_meas_en = meas_reg;

  // ********************************
  // read data
  // ********************************
  logic [7:0] rd_next;
  logic [7:0] rd_data_reg;

  // byte mux, unmapped addresses read zero
  always_comb begin
    rd_next = 8'h00;
    unique case (rd.addr)
      ADDR_TS0: rd_next = ts_view[7:0];
      ADDR_TS1: rd_next = ts_view[15:8];
      ADDR_TS2: rd_next = ts_view[23:16];
      ADDR_STATUS: begin
        rd_next[ST_DRDY] = drdy_reg;
        rd_next[ST_NVM] = nvm_rdy_reg;
        rd_next[ST_FOC] = foc_reg;
        rd_next[ST_SELF] = self_ok_reg;
        rd_next[ST_POR] = por_reg;
      end
      ADDR_IRQ: begin
        rd_next[IRQ_FWM] = irq_reg[2];
        rd_next[IRQ_FFULL] = irq_reg[1];
        rd_next[IRQ_DRDY] = irq_reg[0];
      end
      ADDR_TEMP0: rd_next = temp_reg[7:0];
      ADDR_TEMP1: rd_next = temp_reg[15:8];
      default: rd_next = 8'h00;
    endcase
  end

  // registered read answer
  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      rd_data_reg <= 8'h00;
    end else if (rd.strobe) begin
      rd_data_reg <= rd_next;
    end
  end
  assign rd_data = rd_data_reg;

  // ********************************
  // checks
  // ********************************
  localparam int A_TICK = TICK_CYC - 1;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_s_n);

  sequence s_capture;
    capture && !evt.soft_reset;
  endsequence
  sequence s_read_ts0;
    rd.strobe && !rd.first && (rd.addr == ADDR_TS0) && shadow_on_reg && !capture;
  endsequence

  property p_ts_step;
    tick && !evt.soft_reset |=> ts_reg == $past(ts_reg) + 24'h000001;
  endproperty
  a_ts_step: assert property (p_ts_step) else $error("timestamp step wrong");
  property p_tick_gap;
    disable iff (!rst_s_n || evt.soft_reset)
    tick |=> !tick ##[A_TICK:A_TICK] tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick spacing wrong");
  property p_ts_wrap;
    tick && !evt.soft_reset && (ts_reg == 24'hffffff) |=> ts_reg == TS_RESET;
  endproperty
  a_ts_wrap: assert property (p_ts_wrap) else $error("timestamp wrap wrong");
  property p_shadow;
    s_capture |=> shadow_on_reg && (shadow_reg == $past(ts_reg));
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow not captured");
  property p_shadow_read;
    s_read_ts0 |=> rd_data == $past(shadow_reg[7:0]);
  endproperty
  a_shadow_read: assert property (p_shadow_read) else $error("shadow not returned");
  property p_drdy_clr;
    rd_data_hit && !evt.rate_new |=> !drdy_reg;
  endproperty
  a_drdy_clr: assert property (p_drdy_clr) else $error("rate ready not cleared");
  property p_drdy_keep;
    evt.rate_new |=> drdy_reg;
  endproperty
  a_drdy_keep: assert property (p_drdy_keep) else $error("rate ready event lost");
  property p_por;
    rd_status_hit && !evt.soft_reset |=> !por_reg ##0 (rd_data[ST_POR] == $past(por_reg));
  endproperty
  a_por: assert property (p_por) else $error("power-on flag wrong");
  property p_irq;
    evt.fwm && irq_en[2] && !evt.soft_reset |=> irq_reg[2];
  endproperty
  a_irq: assert property (p_irq) else $error("watermark flag lost");
  property p_no_meas;
    (gyr_pmu == GYR_SUSPEND) && (thermal_power_state == THERM_SUSPEND) |-> !temp_upd;
  endproperty
  a_no_meas: assert property (p_no_meas) else $error("update while suspended");
  property p_temp_load;
    temp_upd && !evt.soft_reset |=> temp_reg == $past(temp_sample);
  endproperty
  a_temp_load: assert property (p_temp_load) else $error("temperature not loaded");

endmodule

// ---- bench/stsr_host.sv ----
// host model that reads the register group one byte at a time
`timescale 1ns/1ps
module stsr_host
  import stsr_pkg::*;
(
  input wire logic clk_sys, // system clock
  output stsr_rd_t rd, // read request to the register group
  input wire logic [7:0] rd_data // read answer
);
  initial rd = '0;
  // ************************************************
  // byte read
  // ************************************************
  // strobe for one cycle, take the answer after the edge that accepted it;
  // the address is inverted once released so a stale value never passes
  task automatic rd_byte(input logic [7:0] addr, input logic first, output logic [7:0] data);
    @(posedge clk_sys);
    rd <= '{strobe: 1'b1, first: first, addr: addr};
    @(posedge clk_sys);
    rd <= '{strobe: 1'b0, first: 1'b0, addr: ~addr};
    #1;
    data = rd_data;
  endtask
endmodule

// ---- bench/stsr_regs_tb.sv ----
// self-checking bench of the timestamp and status register group
`timescale 1ns/1ps
module stsr_regs_tb
  import stsr_pkg::*;
;
  typedef struct packed {
    logic [2:0] cnd;
    logic [2:0] en;
    logic [3:0] ev;
    logic [7:0] st;
    logic [7:0] irq;
  } stsr_row_t;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  stsr_rd_t rd;
  logic [7:0] rd_data;
  stsr_evt_t evt = '0;
  stsr_cond_t cond = '0;
  logic [2:0] irq_en = 3'h0;
  stsr_gyr_pmu_t gyr_pmu = GYR_SUSPEND;
  logic [1:0] thermal_power_state = 2'h0;
  logic [TEMP_W-1:0] temp_sample = 16'h0000;
  logic temp_meas_en;
  logic temp_valid;
  int errors = 0;
  int compares = 0;
  // condition levels, enables, events {rate,fwm,ffull,drdy}, status and irq bytes
  stsr_row_t rows[5] = '{
    '{3'h4, 3'h7, 4'h0, 8'h00, 8'h00},
    '{3'h3, 3'h7, 4'hf, 8'h5a, 8'h70},
    '{3'h0, 3'h0, 4'h7, 8'h10, 8'h00},
    '{3'h1, 3'h4, 4'h7, 8'h12, 8'h40},
    '{3'h2, 3'h3, 4'hb, 8'h58, 8'h30}};
  logic [1:0] gm[5] = '{2'h0, 2'h0, 2'h1, 2'h3, 2'h2};
  logic [1:0] tm[5] = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h1};
  logic me[5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};

  // ************************************************
  // clock, design and host
  // ************************************************
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  stsr_regs #(.TEMP_PERIOD(20)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .rd(rd), .rd_data(rd_data), .evt(evt),
    .cond(cond), .irq_en(irq_en), .gyr_pmu(gyr_pmu),
    .thermal_power_state(thermal_power_state), .temp_sample(temp_sample),
    .temp_meas_en(temp_meas_en), .temp_valid(temp_valid));
  stsr_host host (.clk_sys(clk_sys), .rd(rd), .rd_data(rd_data));

  // ************************************************
  // helpers
  // ************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic f, input logic [7:0] exp);
    logic [7:0] d;
    host.rd_byte(a, f, d);
    check(d, exp);
  endtask
  task automatic pulse(input stsr_evt_t e);
    @(posedge clk_sys);
    evt <= e;
    @(posedge clk_sys);
    evt <= '0;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic do_reset();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    wait_cyc(6);
    rst_n <= 1'b1;
    wait_cyc(3);
  endtask
  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  initial begin
    wait_cyc(20000);
    errors++;
    wrap_up();
  end

  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    wait_cyc(6);
    rst_n <= 1'b1;
    wait_cyc(3);
    rchk(ADDR_STATUS, 1'b1, 8'h11);
    rchk(ADDR_STATUS, 1'b1, 8'h10);
    // table of flag conditions and events
    foreach (rows[i]) begin
      @(posedge clk_sys);
      cond <= rows[i].cnd;
      irq_en <= rows[i].en;
      pulse({rows[i].ev, 2'b00});
      rchk(ADDR_STATUS, 1'b1, rows[i].st);
      rchk(ADDR_IRQ, 1'b1, rows[i].irq);
      rchk(ADDR_IRQ, 1'b1, 8'h00);
      rchk(ADDR_DATA_FIRST + 8'h03, 1'b1, 8'h00);
    end
    // watermark event in the same cycle as the clearing read
    @(posedge clk_sys);
    irq_en <= 3'h7;
    fork
      rchk(ADDR_IRQ, 1'b1, 8'h00);
      pulse(6'b010000);
    join
    rchk(ADDR_IRQ, 1'b1, 8'h40);
    rchk(8'h1c, 1'b1, 8'h00);
    // soft reset restarts timestamp and temperature and sets the power-on flag
    pulse(6'b000010);
    rchk(ADDR_STATUS, 1'b1, 8'h19);
    rchk(ADDR_TEMP1, 1'b1, 8'h80);
    wait_cyc(3 * TICK_CYC + 30);
    rchk(ADDR_TS0, 1'b1, 8'h03);
    rchk(ADDR_TS1, 1'b0, 8'h00);
    rchk(ADDR_TS2, 1'b0, 8'h00);
    // burst from the rate bytes holds the captured count
    rchk(ADDR_DATA_FIRST, 1'b1, 8'h00);
    wait_cyc(TICK_CYC);
    rchk(ADDR_TS0, 1'b0, 8'h03);
    pulse(6'b000001);
    wait_cyc(TICK_CYC);
    rchk(ADDR_TS0, 1'b0, 8'h04);
    rchk(ADDR_TS0, 1'b1, 8'h05);
    // temperature refresh in gyro normal mode
    @(posedge clk_sys);
    gyr_pmu <= GYR_NORMAL;
    temp_sample <= 16'h1234;
    // 20-cycle period: the word changes at the 20th edge after normal is seen
    wait_cyc(17);
    rchk(ADDR_TEMP0, 1'b1, 8'h00);
    rchk(ADDR_TEMP0, 1'b1, 8'h34);
    rchk(ADDR_TEMP1, 1'b1, 8'h12);
    check({7'h00, temp_valid}, 8'h01);
    // measurement enable over five gyro and thermal power state pairs
    for (int k = 0; k < 5; k++) begin
      @(posedge clk_sys);
      gyr_pmu <= stsr_gyr_pmu_t'(gm[k]);
      thermal_power_state <= tm[k];
      wait_cyc(3);
      check({7'h00, temp_meas_en}, {7'h00, me[k]});
      check({7'h00, temp_valid}, {7'h00, gm[k] == 2'h1});
    end
    // both suspended: no update
    @(posedge clk_sys);
    gyr_pmu <= GYR_SUSPEND;
    thermal_power_state <= THERM_SUSPEND;
    temp_sample <= 16'h5678;
    wait_cyc(50);
    rchk(ADDR_TEMP0, 1'b1, 8'h34);
    // hardware reset values
    @(posedge clk_sys);
    cond <= '0;
    do_reset();
    rchk(ADDR_STATUS, 1'b1, 8'h11);
    rchk(ADDR_TEMP0, 1'b1, 8'h00);
    rchk(ADDR_TEMP1, 1'b1, 8'h80);
    rchk(ADDR_TS0, 1'b1, 8'h00);
    rchk(ADDR_IRQ, 1'b1, 8'h00);
    wrap_up();
  end
endmodule
